//--- core/flash_secprot_pkg.sv
// Constants and carrier types for the security-register and protection-mode logic.
// Assumes a serial/quad flash host on the pins and array engines that report events.
package flash_secprot_pkg;

  // ----------------------------------------------------------------
  // Security register layout
  // ----------------------------------------------------------------
  localparam int SEC_PROTECTION_MODE_SELECT = 7;
  localparam int SEC_EFAIL = 6;
  localparam int SEC_PFAIL = 5;
  localparam int SEC_RSVD = 4;
  localparam int SEC_ESB = 3;
  localparam int SEC_PSB = 2;
  localparam int SEC_OTP_LOCKDOWN_FLAG = 1;
  localparam int SEC_FACTORY = 0;
  localparam logic [7:0] SECREG_RST = 8'h00;

  // ----------------------------------------------------------------
  // Opcodes and command framing
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_EXIT_OTP = 8'h51;
  localparam logic [7:0] OP_ENTER_OTP = 8'h52;
  localparam logic [7:0] OP_READ_SECREG = 8'h53;
  localparam logic [7:0] OP_WRITE_SECREG = 8'h54;
  localparam logic [7:0] OP_PROT_SELECT = 8'h55;
  localparam logic [3:0] SPI_OP_EDGES = 4'h8;
  localparam logic [3:0] QPI_OP_EDGES = 4'h2;
  localparam logic [2:0] SPI_OUT_SLOTS = 3'h7;
  localparam logic [2:0] QPI_OUT_SLOTS = 3'h1;

  // ----------------------------------------------------------------
  // Memory geometry
  // ----------------------------------------------------------------
  localparam int FLASH_ADDR_W = 26;
  localparam int SECTOR_SHIFT = 12;
  localparam int BLOCK_SHIFT = 16;
  localparam int SECTORS_PER_BLOCK = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PH_IDLE, PH_OPCODE, PH_READ, PH_DATA} phase_type;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] sio;
  } pins_type;

  typedef struct packed {
    logic erase_done;
    logic erase_fail;
    logic prog_done;
    logic prog_fail;
    logic erase_susp;
    logic erase_resume;
    logic prog_susp;
    logic prog_resume;
  } flash_evt_type;

  typedef struct packed {
    logic factory_lock;
    logic otp_lockdown_flag;
    logic protection_mode_select;
  } nv_bits_type;

endpackage : flash_secprot_pkg

//--- core/flash_security_protect_select.sv
// Security register, secured-OTP mode entry/exit and protection-mode selection.
// Assumes pins come from outside the i_mclk domain and SCLK is far slower than i_mclk.
// Contract
// R1 - Exit-OTP command, framed alone, returns the device to normal array access.
// R2 - Opcode takes 8 clocks single-line or 2 clocks quad; upper lines ignored single.
// R3 - Security register read is serviced at any time, even while busy.
// R4 - Read shifts register contents out repeatedly until chip select rises.
// R5 - Host must set the write enable latch before a security register write.
// R6 - Register write sets lockdown bit1; once set it and OTP never change.
// R7 - Register write is rejected unless chip select rises exactly on the byte boundary.
// R8 - Erase fail bit6 sets on failed or protected erase, clears on success.
// R9 - Program fail bit5 sets on failed or protected program, clears on success.
// R10 - Failure flags only report; they never stop any operation.
// R11 - Erase-suspended bit3 is 1 while an erase is suspended, default 0.
// R12 - Program-suspended bit2 is 1 while a program is suspended, default 0.
// R13 - Bit0 reports factory lock of the OTP area; commands never change it.
// R14 - Mode selector bit7 defaults 0, one-time set to 1, modes exclusive.
// R15 - Protection-select command with write enable sets the mode selector.
// R16 - With selector 0, the four block-protect bits alone decide write protection.
// R17 - With selector 1, block-protect bits are ignored and sector locking is active.
// R18 - With selector 1, every block powers up protected by its volatile bit.
// R19 - One lock pair per 4KB sector at both 64KB ends, per 64KB block elsewhere.
// R20 - Program and erase are inhibited when either lock bit of the unit is set.
// R21 - Default sub-mode allows persistent changes; password sub-mode needs a valid password.
// R22 - In OTP mode main array access is blocked; reads and programs go to OTP.
// R23 - Reserved bit4 reads zero; volatile flags clear on reset.
`timescale 1ns/100ps
module flash_security_protect_select import flash_secprot_pkg::*; #(
  parameter int ADDR_W = FLASH_ADDR_W
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire pins_type i_pins,
  input wire logic i_quad_mode,
  input wire logic i_wel,
  input wire logic i_busy,
  input wire flash_evt_type i_evt,
  input wire nv_bits_type i_nv,
  input wire logic [3:0] i_block_protect_field,
  input wire logic [ADDR_W-1:0] i_chk_addr,
  input wire logic i_lock_wr,
  input wire logic i_lock_all,
  input wire logic i_lock_volatile,
  input wire logic i_lock_value,
  input wire logic [ADDR_W-1:0] i_lock_addr,
  input wire logic i_password_mode,
  input wire logic i_password_ok,
  input wire logic i_persist_freeze,
  output logic [3:0] o_sio_o,
  output logic [3:0] o_sio_oe,
  output logic [7:0] o_secreg,
  output logic o_otp_mode,
  output logic o_array_blocked,
  output logic o_protection_mode_select,
  output logic o_asp_enable,
  output logic o_wel_clear,
  output logic o_otp_lockdown_flag_prog,
  output logic o_protection_mode_select_prog,
  output logic o_write_inhibit
);

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_BLOCKS = 2 ** (ADDR_W - BLOCK_SHIFT);
  localparam int UNITS = NUM_BLOCKS - 2 + 2 * SECTORS_PER_BLOCK;
  localparam int UIDX_W = $clog2(UNITS);
  localparam int BLK_W = ADDR_W - BLOCK_SHIFT;

  if (ADDR_W < BLOCK_SHIFT + 2 || ADDR_W > 31) begin : g_bad_addr
    $error("ADDR_W must lie between 18 and 31");
  end

  // Sectors of the bottom block first, then middle blocks, then sectors of the top block
  function automatic logic [UIDX_W-1:0] unit_of(input logic [ADDR_W-1:0] a);
    logic [BLK_W-1:0] blk;
    logic [3:0] sec;
    blk = a[ADDR_W-1:BLOCK_SHIFT];
    sec = a[BLOCK_SHIFT-1:SECTOR_SHIFT];
    if (blk == '0) begin
      unit_of = UIDX_W'(sec);
    end else if (blk == '1) begin
      unit_of = UIDX_W'(NUM_BLOCKS - 2 + SECTORS_PER_BLOCK + int'(sec));
    end else begin
      unit_of = UIDX_W'(int'(blk) - 1 + SECTORS_PER_BLOCK);
    end
  endfunction : unit_of

  // Block-protect field covers the top 2^(bp-1) blocks; large codes cover the whole array
  function automatic logic bp_hit(input logic [3:0] bp, input logic [ADDR_W-1:0] a);
    int span;
    span = 1 << (int'(bp) - 1);
    if (bp == 4'h0) begin
      bp_hit = 1'b0;
    end else if (span >= NUM_BLOCKS) begin
      bp_hit = 1'b1;
    end else begin
      bp_hit = int'(a[ADDR_W-1:BLOCK_SHIFT]) >= NUM_BLOCKS - span;
    end
  endfunction : bp_hit

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic ck_m;
    logic ck_s;
    logic ck_d;
    logic [3:0] sio_m;
    logic [3:0] sio_s;
    phase_type phase;
    logic [7:0] shreg;
    logic [3:0] edges;
    logic [7:0] opcode;
    logic extra;
    logic [7:0] out_sh;
    logic [2:0] out_cnt;
    logic [3:0] sio_o;
    logic [3:0] sio_oe;
    logic init_done;
    logic otp_mode;
    logic factory;
    logic otp_lockdown_flag;
    logic protection_mode_select;
    logic efail;
    logic pfail;
    logic erase_suspended_flag;
    logic program_suspended_flag;
    logic pers_unlock;
    logic wel_clear;
    logic otp_lockdown_flag_prog;
    logic protection_mode_select_prog;
    logic inhibit;
    logic [UNITS-1:0] pers;
    logic [UNITS-1:0] vol;
  } st_type;

  st_type s_q;
  st_type s_d;
  logic ck_rise;
  logic ck_fall;
  logic cs_rise;
  logic frame_ok;
  logic [7:0] secreg;
  logic [7:0] op_next;
  logic [3:0] op_edges;
  logic [2:0] out_last;
  logic [UIDX_W-1:0] lock_idx;
  logic [UIDX_W-1:0] chk_idx;

  assign ck_rise = s_q.ck_s & ~s_q.ck_d;
  assign ck_fall = ~s_q.ck_s & s_q.ck_d;
  assign cs_rise = s_q.cs_s & ~s_q.cs_d;
  // Nothing clocked after the opcode: the rise sits exactly on its byte boundary
  assign frame_ok = cs_rise && s_q.phase == PH_DATA && !s_q.extra; // R7
  assign secreg = {s_q.protection_mode_select, s_q.efail, s_q.pfail, 1'b0, s_q.erase_suspended_flag, s_q.program_suspended_flag, s_q.otp_lockdown_flag,
                   s_q.factory}; // R23
  assign op_edges = i_quad_mode ? QPI_OP_EDGES : SPI_OP_EDGES; // R2
  assign op_next = i_quad_mode ? {s_q.shreg[3:0], s_q.sio_s} : {s_q.shreg[6:0], s_q.sio_s[0]};
  assign out_last = i_quad_mode ? QPI_OUT_SLOTS : SPI_OUT_SLOTS;
  assign lock_idx = unit_of(i_lock_addr); // R19
  assign chk_idx = unit_of(i_chk_addr);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.cs_m = i_pins.cs_n;
    s_d.cs_s = s_q.cs_m;
    s_d.cs_d = s_q.cs_s;
    s_d.ck_m = i_pins.sclk;
    s_d.ck_s = s_q.ck_m;
    s_d.ck_d = s_q.ck_s;
    s_d.sio_m = i_pins.sio;
    s_d.sio_s = s_q.sio_m;
    s_d.wel_clear = 1'b0;
    s_d.otp_lockdown_flag_prog = 1'b0;
    s_d.protection_mode_select_prog = 1'b0;

    // Non-volatile bits are taken once, the cycle after reset release
    if (!s_q.init_done) begin
      s_d.init_done = 1'b1;
      s_d.factory = i_nv.factory_lock; // R13
      s_d.otp_lockdown_flag = i_nv.otp_lockdown_flag;
      s_d.protection_mode_select = i_nv.protection_mode_select;
      s_d.pers_unlock = ~i_password_mode; // R21
    end

    // Serial framing
    if (s_q.cs_s) begin
      s_d.phase = PH_IDLE;
      s_d.sio_oe = 4'h0;
    end else begin
      unique case (s_q.phase)
        PH_IDLE: begin
          s_d.phase = PH_OPCODE;
          s_d.edges = 4'h0;
          s_d.extra = 1'b0;
        end
        PH_OPCODE: begin
          if (ck_rise) begin
            s_d.shreg = op_next;
            s_d.edges = s_q.edges + 4'h1;
            if (s_q.edges + 4'h1 == op_edges) begin // R2
              s_d.opcode = op_next;
              s_d.out_sh = secreg;
              s_d.out_cnt = 3'h0;
              s_d.phase = (op_next == OP_READ_SECREG) ? PH_READ : PH_DATA; // R3
            end
          end
        end
        PH_READ: begin
          // Drive on falling edges and reload a fresh image after each byte
          if (ck_fall) begin // R4
            if (i_quad_mode) begin
              s_d.sio_o = s_q.out_sh[7:4];
              s_d.sio_oe = 4'hf;
              s_d.out_sh = {s_q.out_sh[3:0], 4'h0};
            end else begin
              s_d.sio_o = {2'b00, s_q.out_sh[7], 1'b0};
              s_d.sio_oe = 4'h2;
              s_d.out_sh = {s_q.out_sh[6:0], 1'b0};
            end
            s_d.out_cnt = s_q.out_cnt + 3'h1;
            if (s_q.out_cnt == out_last) begin
              s_d.out_cnt = 3'h0;
              s_d.out_sh = secreg;
            end
          end
        end
        PH_DATA: begin
          if (ck_rise) begin
            s_d.extra = 1'b1;
          end
        end
      endcase
    end

    // Commands execute on the chip-select rise
    if (frame_ok) begin
      if (s_q.opcode == OP_EXIT_OTP) begin
        s_d.otp_mode = 1'b0; // R1
      end else if (s_q.opcode == OP_ENTER_OTP) begin
        s_d.otp_mode = 1'b1; // R22
      end else if (s_q.opcode == OP_WRITE_SECREG && i_wel && !i_busy) begin // R5
        s_d.wel_clear = 1'b1;
        if (!s_q.otp_lockdown_flag) begin
          s_d.otp_lockdown_flag = 1'b1; // R6
          s_d.otp_lockdown_flag_prog = 1'b1;
        end
      end else if (s_q.opcode == OP_PROT_SELECT && i_wel && !i_busy) begin
        s_d.wel_clear = 1'b1;
        if (!s_q.protection_mode_select) begin // R14
          s_d.protection_mode_select = 1'b1; // R15
          s_d.protection_mode_select_prog = 1'b1;
        end
      end
    end

    // Status flags; they only report and feed nothing that stops an operation
    if (i_evt.erase_done) begin // R10
      s_d.efail = i_evt.erase_fail; // R8
    end
    if (i_evt.prog_done) begin
      s_d.pfail = i_evt.prog_fail; // R9
    end
    s_d.erase_suspended_flag = (s_q.erase_suspended_flag & ~i_evt.erase_resume) | i_evt.erase_susp; // R11
    s_d.program_suspended_flag = (s_q.program_suspended_flag & ~i_evt.prog_resume) | i_evt.prog_susp; // R12

    // Sector locking only exists in advanced mode
    if (s_q.protection_mode_select) begin // R17
      s_d.pers_unlock = (s_q.pers_unlock & ~i_persist_freeze) | i_password_ok; // R21
      if (i_lock_wr && i_lock_volatile) begin
        if (i_lock_all) begin
          s_d.vol = {UNITS{i_lock_value}};
        end else begin
          s_d.vol[lock_idx] = i_lock_value;
        end
      end else if (i_lock_wr && s_q.pers_unlock) begin
        // Persistent bits clear only as a whole, set one at a time
        if (i_lock_all) begin
          s_d.pers = '0;
        end else begin
          s_d.pers[lock_idx] = 1'b1;
        end
      end
    end

    if (s_q.protection_mode_select) begin
      s_d.inhibit = s_q.pers[chk_idx] | s_q.vol[chk_idx]; // R20
    end else begin
      s_d.inhibit = bp_hit(i_block_protect_field, i_chk_addr); // R16
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      s_q <= '0;
      s_q.cs_m <= 1'b1;
      s_q.cs_s <= 1'b1;
      s_q.cs_d <= 1'b1;
      // Persistent bits come out of reset cleared; nothing reloads them from a backing store
      s_q.vol <= '1; // R18
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sio_o = s_q.sio_o;
  assign o_sio_oe = s_q.sio_oe;
  assign o_otp_mode = s_q.otp_mode;
  assign o_array_blocked = s_q.otp_mode; // R22
  assign o_protection_mode_select = s_q.protection_mode_select;
  assign o_asp_enable = s_q.protection_mode_select;
  assign o_wel_clear = s_q.wel_clear;
  assign o_otp_lockdown_flag_prog = s_q.otp_lockdown_flag_prog;
  assign o_protection_mode_select_prog = s_q.protection_mode_select_prog;
  assign o_write_inhibit = s_q.inhibit;

  // Image is registered one cycle behind the bits it reports
  logic [7:0] secreg_q;
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      secreg_q <= SECREG_RST;
    end else begin
      secreg_q <= secreg;
    end
  end
  assign o_secreg = secreg_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  otp_exit_a: assert property (frame_ok && s_q.opcode == OP_EXIT_OTP |=> !o_otp_mode) // R1
    else $error("exit command left OTP mode set");
  opcode_len_a: assert property (s_q.phase == PH_OPCODE |-> s_q.edges < SPI_OP_EDGES) // R2
    else $error("opcode phase overran");
  read_busy_a: assert property (s_q.phase == PH_READ && !s_q.cs_s && ck_fall |=> // R3
      o_sio_oe != 4'h0)
    else $error("read not driven");
  read_data_a: assert property (s_q.phase == PH_READ && !s_q.cs_s && ck_fall && !i_quad_mode
      |=> o_sio_o[1] == $past(s_q.out_sh[7])) // R4
    else $error("wrong serial output bit");
  wel_gate_a: assert property (o_wel_clear |-> $past(i_wel)) // R5
    else $error("write done without enable latch");
  otp_lockdown_flag_sticky_a: assert property (s_q.init_done && o_secreg[SEC_OTP_LOCKDOWN_FLAG] |=> // R6
      o_secreg[SEC_OTP_LOCKDOWN_FLAG])
    else $error("lockdown bit cleared");
  boundary_a: assert property (cs_rise && s_q.extra |=> !o_otp_lockdown_flag_prog && !o_protection_mode_select_prog) // R7
    else $error("misframed write executed");
  efail_a: assert property (i_evt.erase_done |=> ##1 o_secreg[SEC_EFAIL] == // R8
      $past(i_evt.erase_fail, 2))
    else $error("erase fail flag wrong");
  pfail_a: assert property (i_evt.prog_done |=> ##1 o_secreg[SEC_PFAIL] == // R9
      $past(i_evt.prog_fail, 2))
    else $error("program fail flag wrong");
  esb_set_a: assert property (i_evt.erase_susp |=> ##1 o_secreg[SEC_ESB]) // R11
    else $error("erase suspend flag not set");
  psb_set_a: assert property (i_evt.prog_susp |=> ##1 o_secreg[SEC_PSB]) // R12
    else $error("program suspend flag not set");
  rsvd_zero_a: assert property (o_secreg[SEC_RSVD] == 1'b0) // R23
    else $error("reserved bit set");
  protection_mode_select_sticky_a: assert property (s_q.init_done && o_protection_mode_select |=> // R14
      o_protection_mode_select)
    else $error("mode selector returned to zero");
  inhibit_a: assert property (s_q.protection_mode_select && s_q.vol[chk_idx] |=> o_write_inhibit) // R20
    else $error("locked unit not inhibited");

endmodule : flash_security_protect_select

//--- bench/flash_host_model.sv
// Host side of the serial flash link: frames commands on chip select, clock and I/O lines.
// Assumes the bench resolves the I/O lines from both parties and calls frame() per command.
`timescale 1ns/100ps
module flash_host_model import flash_secprot_pkg::*; (
  input wire logic i_mclk,
  input wire logic [3:0] i_sio,
  output pins_type o_pins,
  output logic o_rd_strobe,
  output logic [7:0] o_rd_byte
);
  initial begin
    o_pins = {1'b1, 1'b0, 4'h0};
    o_rd_strobe = 1'b0;
    o_rd_byte = 8'h00;
  end

  // Half a link clock period, 400 ns, always changing just after a system edge
  task automatic half();
    repeat (4) @(posedge i_mclk);
    #1;
  endtask : half

  // ----------------------------------------------------------------
  // One frame: opcode, then extra clocks and read bytes, clock idles low
  // ----------------------------------------------------------------
  task automatic frame(input logic [7:0] op, input logic quad, input logic [2:0] upper,
                       input int extra, input int nrd);
    int i;
    int per;
    logic [7:0] b;
    per = quad ? 2 : 8;
    b = 8'h00;
    @(posedge i_mclk);
    #1;
    o_pins.cs_n = 1'b0;
    half();
    for (i = 0; i < per; i++) begin
      if (quad) begin
        o_pins.sio = (i == 0) ? op[7:4] : op[3:0];
      end else begin
        o_pins.sio = {upper, op[7-i]};
      end
      half();
      o_pins.sclk = 1'b1;
      half();
      o_pins.sclk = 1'b0;
    end
    // Released lines keep toggling so a stale level can never pass for read data
    for (i = 0; i < extra + nrd * per; i++) begin
      o_pins.sio = ~o_pins.sio;
      half();
      o_pins.sclk = 1'b1;
      b = quad ? {b[3:0], i_sio} : {b[6:0], i_sio[1]};
      if (i >= extra && (i - extra + 1) % per == 0) begin
        o_rd_byte = b;
        o_rd_strobe = 1'b1;
      end
      half();
      o_pins.sclk = 1'b0;
      o_rd_strobe = 1'b0;
    end
    half();
    o_pins.cs_n = 1'b1;
    half();
  endtask : frame
endmodule : flash_host_model

//--- bench/flash_security_protect_select_test.sv
// Self-checking bench for the security register and protection mode logic.
// Assumes the host model on the pins; array events and lock requests come from here.
`timescale 1ns/100ps
module flash_security_protect_select_test import flash_secprot_pkg::*;;
  localparam int AW = 18;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_quad_mode = 1'b0, i_wel = 1'b0, i_busy = 1'b0;
  flash_evt_type i_evt = '0;
  nv_bits_type i_nv = {1'b1, 1'b0, 1'b0};
  logic [3:0] i_bp = 4'h0;
  logic [AW-1:0] i_chk_addr = '0, i_lock_addr = '0;
  logic i_lock_wr = 1'b0, i_lock_volatile = 1'b0, i_lock_value = 1'b0;
  logic tie0 = 1'b0;
  pins_type host_pins, pins;
  logic [3:0] sio_o, sio_oe, sio_w;
  logic [7:0] secreg, rd_byte, rnd = 8'h4a;
  logic otp, blocked, msel, asp, wel_clr, otp_lockdown_flag_p, protection_mode_select_p, inhibit, rd_strobe, rd_prev;
  logic [1:0] exp_pulse[$];
  logic [7:0] exp_read[$];
  int n_errors = 0, checks = 0, i, k;
  flash_evt_type evt_tab[8] = '{8'hc0, 8'h30, 8'h08, 8'h02, 8'h80, 8'h20, 8'h04, 8'h01};
  logic [7:0] sec_tab[8] = '{8'h43, 8'h63, 8'h6b, 8'h6f, 8'h2f, 8'h0f, 8'h07, 8'h03};

  initial begin
    forever #50 i_mclk = ~i_mclk;
  end
  assign sio_w = (sio_oe & sio_o) | (~sio_oe & host_pins.sio);
  assign pins = {host_pins.cs_n, host_pins.sclk, sio_w};

  flash_host_model flash_host_model_inst (.i_mclk(i_mclk), .i_sio(sio_w), .o_pins(host_pins),
    .o_rd_strobe(rd_strobe), .o_rd_byte(rd_byte));
  flash_security_protect_select #(.ADDR_W(AW)) flash_security_protect_select_inst (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_pins(pins), .i_quad_mode(i_quad_mode),
    .i_wel(i_wel), .i_busy(i_busy), .i_evt(i_evt), .i_nv(i_nv),
    .i_block_protect_field(i_bp), .i_chk_addr(i_chk_addr), .i_lock_wr(i_lock_wr),
    .i_lock_all(tie0), .i_lock_volatile(i_lock_volatile), .i_lock_value(i_lock_value),
    .i_lock_addr(i_lock_addr), .i_password_mode(tie0), .i_password_ok(tie0),
    .i_persist_freeze(tie0), .o_sio_o(sio_o), .o_sio_oe(sio_oe), .o_secreg(secreg),
    .o_otp_mode(otp), .o_array_blocked(blocked), .o_protection_mode_select(msel),
    .o_asp_enable(asp), .o_wel_clear(wel_clr), .o_otp_lockdown_flag_prog(otp_lockdown_flag_p), .o_protection_mode_select_prog(protection_mode_select_p),
    .o_write_inhibit(inhibit));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d, n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic cmd(input logic [7:0] op, input int extra, input int nrd);
    rnd = lfsr_next(rnd);
    flash_host_model_inst.frame(op, i_quad_mode, rnd[2:0], extra, nrd);
    repeat (4) @(posedge i_mclk);
    #1;
  endtask : cmd

  task automatic evt(input flash_evt_type e);
    i_evt = e;
    @(posedge i_mclk);
    #1;
    i_evt = '0;
    repeat (3) @(posedge i_mclk);
    #1;
  endtask : evt

  task automatic inh(input logic [AW-1:0] a, input logic exp);
    @(posedge i_mclk);
    #1;
    i_chk_addr = a;
    repeat (3) @(negedge i_mclk);
    check("write inhibit", {7'h0, exp}, {7'h0, inhibit});
  endtask : inh

  task automatic lock(input logic [AW-1:0] a, input logic vol, input logic val);
    @(posedge i_mclk);
    #1;
    {i_lock_addr, i_lock_volatile, i_lock_value, i_lock_wr} = {a, vol, val, 1'b1};
    @(posedge i_mclk);
    #1;
    i_lock_wr = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask : lock

  // ----------------------------------------------------------------
  // Monitor: every result on the outputs consumes the oldest note
  // ----------------------------------------------------------------
  always @(negedge i_mclk) begin
    if (wel_clr === 1'b1) begin
      if (exp_pulse.size() == 0) begin
        n_errors++;
        $display("unexpected accepted write: expected none, seen %b", {otp_lockdown_flag_p, protection_mode_select_p});
      end else check("program pulses", {6'h0, exp_pulse.pop_front()}, {6'h0, otp_lockdown_flag_p, protection_mode_select_p});
    end
    if (rd_strobe === 1'b1 && rd_prev !== 1'b1) begin
      if (exp_read.size() == 0) begin
        n_errors++;
        $display("unexpected read byte: expected none, seen %h", rd_byte);
      end else check("read byte", exp_read.pop_front(), rd_byte);
    end
    rd_prev <= rd_strobe;
  end

  initial begin
    repeat (60000) @(posedge i_mclk);
    n_errors++;
    $display("unexpected hang: expected end of run, seen %0d checks", checks);
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge i_mclk);
    check("register in reset", 8'h00, secreg);
    #1;
    i_resetn = 1'b1;
    repeat (4) @(posedge i_mclk);
    check("register after reset", 8'h01, secreg);
    cmd(OP_ENTER_OTP, 0, 0);
    check("otp mode", 8'h03, {6'h0, otp, blocked});
    i_quad_mode = 1'b1;
    cmd(OP_EXIT_OTP, 0, 0);
    check("otp mode", 8'h00, {6'h0, otp, blocked});
    i_quad_mode = 1'b0;
    i_busy = 1'b1;
    exp_read.push_back(8'h01);
    exp_read.push_back(8'h01);
    cmd(OP_READ_SECREG, 0, 2);
    check("output enable", 8'h00, {4'h0, sio_oe});
    cmd(OP_WRITE_SECREG, 0, 0);
    i_busy = 1'b0;
    cmd(OP_WRITE_SECREG, 0, 0);
    i_wel = 1'b1;
    cmd(OP_WRITE_SECREG, 1, 0);
    exp_pulse.push_back(2'b10);
    cmd(OP_WRITE_SECREG, 0, 0);
    i_wel = 1'b0;
    check("lockdown bit", 8'h03, secreg);
    for (i = 0; i < 8; i++) begin
      evt(evt_tab[i]);
      check("status flags", sec_tab[i], secreg);
      if (i == 3) begin
        i_quad_mode = 1'b1;
        exp_read.push_back(8'h6f);
        cmd(OP_READ_SECREG, 0, 1);
        i_quad_mode = 1'b0;
      end
    end
    i_bp = 4'h1;
    inh(18'h3ffff, 1'b1);
    inh(18'h00000, 1'b0);
    i_bp = 4'h0;
    inh(18'h3ffff, 1'b0);
    i_wel = 1'b1;
    exp_pulse.push_back(2'b01);
    cmd(OP_PROT_SELECT, 0, 0);
    i_wel = 1'b0;
    check("mode select", 8'hc3, {msel, asp, 6'h0} | secreg);
    inh(18'h00000, 1'b1);
    lock(18'h00000, 1'b1, 1'b0);
    i_bp = 4'hf;
    inh(18'h00000, 1'b0);
    inh(18'h01000, 1'b1);
    lock(18'h10000, 1'b1, 1'b0);
    inh(18'h1ffff, 1'b0);
    lock(18'h10000, 1'b0, 1'b1);
    inh(18'h1ffff, 1'b1);
    for (k = 0; k < 50 && (exp_pulse.size() + exp_read.size()) > 0; k++) @(posedge i_mclk);
    if ((exp_pulse.size() + exp_read.size()) > 0) begin
      n_errors++;
      $display("unexpected missing results: expected 0, seen %0d",
        exp_pulse.size() + exp_read.size());
    end
    give_verdict();
  end
endmodule : flash_security_protect_select_test
